// ---- battery_temp_zone_charge_control.sv ----
// temperature zone sorting, charge code selection and rail margin check
`timescale 1ns/1ps
`include "temp_zone_cfg.svh"

module battery_temp_zone_charge_control (
    // apb slave
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic [7:0]                paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // analog comparators and charge input
    input  wire temp_zone_pkg::cmp_t       cmp_raw,
    input  wire logic                      charge_input_valid,
    // charger core
    input  wire temp_zone_pkg::chg_state_t core_next_state,
    output temp_zone_pkg::chg_state_t      charge_state,
    output logic                           timers_paused,
    output logic                           charge_paused,
    output logic                           temp_modified,
    output logic      [5:0]                charge_voltage_out,
    output logic      [5:0]                charge_current_out,
    // analog controls
    output temp_zone_pkg::trip_sel_t       trip_sel,
    output logic      [3:0][10:0]          trip_mv,
    output logic      [3:0]                analog_probe_sel,
    output logic                           sensor_bias_on,
    // interrupt lines
    output logic                           temp_irq,
    output logic                           margin_irq
);

    // ==========================================================
    // helpers

    // voltage code to millivolts
    function automatic logic [12:0] code_mv(input logic [5:0] code,
                                            input logic [12:0] base,
                                            input logic [12:0] step);
        code_mv = 13'(base + 13'(code) * step);
    endfunction : code_mv

    // trip voltage table, highest first, in millivolts
    function automatic logic [10:0] trip_tbl(input logic [3:0] idx);
        case (idx)
            4'h0:    trip_tbl = 11'h400; // 1.024
            4'h1:    trip_tbl = 11'h3D0; // 0.976
            4'h2:    trip_tbl = 11'h39B; // 0.923
            4'h3:    trip_tbl = 11'h363; // 0.867
            4'h4:    trip_tbl = 11'h327; // 0.807
            4'h5:    trip_tbl = 11'h2EB; // 0.747
            4'h6:    trip_tbl = 11'h1FF; // 0.511
            4'h7:    trip_tbl = 11'h1CB; // 0.459
            4'h8:    trip_tbl = 11'h19B; // 0.411
            4'h9:    trip_tbl = 11'h16F; // 0.367
            4'hA:    trip_tbl = 11'h147; // 0.327
            default: trip_tbl = 11'h123; // 0.291
        endcase
    endfunction : trip_tbl

    // ==========================================================
    // software registers
    logic                     en_reg, en_next;
    temp_zone_pkg::trip_sel_t trip_reg, trip_next;
    logic [3:0]               mux_reg, mux_next;
    logic [5:0]               cv_reg, cv_next;
    logic [5:0]               alt_cv_reg, alt_cv_next;
    logic [5:0]               cc_reg, cc_next;
    logic [5:0]               alt_cc_reg, alt_cc_next;
    logic [5:0]               rail_reg, rail_next;
    logic [1:0]               flag_reg, flag_next;
    logic [1:0]               mask_reg, mask_next;
    logic [31:0]              rdata_reg, rdata_next;
    logic                     wr, hit, margin_bad, zone_change;
    logic [1:0]               set_flags, clr_flags;

    // zone and state registers
    temp_zone_pkg::cmp_t       cmp_s1, cmp_s2;
    logic                      valid_s1, valid_s2;
    temp_zone_pkg::zone_t      zone_reg, zone_next;
    temp_zone_pkg::chg_state_t state_reg, state_next;
    temp_zone_pkg::chg_state_t saved_reg, saved_next;
    logic                      fault_zone;

    // output registers
    logic [5:0]       volt_next, curr_next;
    logic             mod_next, pause_next, bias_next;
    logic [3:0][10:0] mv_next;

    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign hit = (paddr == `ADDR_CFG) || (paddr == `ADDR_CHGV) ||
                 (paddr == `ADDR_CHGI) || (paddr == `ADDR_RAIL) ||
                 (paddr == `ADDR_STAT) || (paddr == `ADDR_FLAG) ||
                 (paddr == `ADDR_MASK);
    assign pslverr = psel && penable && !hit;
    assign prdata = rdata_reg;

    assign margin_bad = (cv_reg != 6'h00) &&
        (13'(code_mv(cv_reg, `CV_BASE_MV, `CV_STEP_MV) + `MARGIN_MV) >
         code_mv(rail_reg, `RAIL_BASE_MV, `RAIL_STEP_MV));
    assign zone_change = (zone_next != zone_reg);
    assign set_flags = {margin_bad, zone_change};
    assign clr_flags = (wr && paddr == `ADDR_FLAG) ? pwdata[1:0] : 2'h0;

    // ==========================================================
    // register file next values
    always_comb begin
        en_next = en_reg;
        trip_next = trip_reg;
        mux_next = mux_reg;
        cv_next = cv_reg;
        alt_cv_next = alt_cv_reg;
        cc_next = cc_reg;
        alt_cc_next = alt_cc_reg;
        rail_next = rail_reg;
        mask_next = mask_reg;
        if (wr && paddr == `ADDR_CFG) begin
            en_next = pwdata[`CFG_EN_BIT];
            trip_next = pwdata[`CFG_TRIP_LSB +: 8];
            mux_next = pwdata[`CFG_MUX_LSB +: 4];
        end else if (wr && paddr == `ADDR_CHGI) begin
            cc_next = pwdata[5:0];
            alt_cc_next = pwdata[`ALT_LSB +: 6];
        end else if (wr && paddr == `ADDR_RAIL) begin
            rail_next = pwdata[5:0];
        end else if (wr && paddr == `ADDR_MASK) begin
            mask_next = pwdata[1:0];
        end
        if (wr && paddr == `ADDR_CHGV) begin
            cv_next = pwdata[5:0];
            alt_cv_next = pwdata[`ALT_LSB +: 6];
        end else if (margin_bad) begin
            cv_next = cv_reg - 6'h01;
        end
        // sticky flags, set wins over clear
        flag_next = (flag_reg & ~clr_flags) | set_flags;
        // read data captured in the setup cycle
        rdata_next = rdata_reg;
        if (psel && !penable && !pwrite) begin
            rdata_next = 32'h0;
            if (paddr == `ADDR_CFG) begin
                rdata_next = {12'h0, mux_reg, trip_reg, 7'h0, en_reg};
            end else if (paddr == `ADDR_CHGV) begin
                rdata_next = {18'h0, alt_cv_reg, 2'h0, cv_reg};
            end else if (paddr == `ADDR_CHGI) begin
                rdata_next = {18'h0, alt_cc_reg, 2'h0, cc_reg};
            end else if (paddr == `ADDR_RAIL) begin
                rdata_next = {26'h0, rail_reg};
            end else if (paddr == `ADDR_STAT) begin
                rdata_next = {24'h0, sensor_bias_on, state_reg, 1'b0,
                              zone_reg};
            end else if (paddr == `ADDR_FLAG) begin
                rdata_next = {30'h0, flag_reg};
            end else if (paddr == `ADDR_MASK) begin
                rdata_next = {30'h0, mask_reg};
            end
        end
    end

    // register file storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 1'b0;
            trip_reg <= 8'h00;
            mux_reg <= 4'h0;
            cv_reg <= `CV_RESET;
            alt_cv_reg <= `CV_RESET;
            cc_reg <= `CC_RESET;
            alt_cc_reg <= `CC_RESET;
            rail_reg <= `RAIL_RESET;
            flag_reg <= 2'h0;
            mask_reg <= `MASK_RESET;
            rdata_reg <= 32'h0;
        end else begin
            en_reg <= en_next;
            trip_reg <= trip_next;
            mux_reg <= mux_next;
            cv_reg <= cv_next;
            alt_cv_reg <= alt_cv_next;
            cc_reg <= cc_next;
            alt_cc_reg <= alt_cc_next;
            rail_reg <= rail_next;
            flag_reg <= flag_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================
    // zone decode and charge state

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_s1 <= 4'h0;
            cmp_s2 <= 4'h0;
            valid_s1 <= 1'b0;
            valid_s2 <= 1'b0;
        end else begin
            cmp_s1 <= cmp_raw;
            cmp_s2 <= cmp_s1;
            valid_s1 <= charge_input_valid;
            valid_s2 <= valid_s1;
        end
    end

    assign fault_zone = (zone_reg == temp_zone_pkg::ZONE_HOT) ||
                        (zone_reg == temp_zone_pkg::ZONE_COLD);

    // zone and state next values
    always_comb begin
        if (!en_reg) begin
            zone_next = temp_zone_pkg::ZONE_OFF;
        end else if (cmp_s2.below_hot) begin
            zone_next = temp_zone_pkg::ZONE_HOT;
        end else if (cmp_s2.below_warm) begin
            zone_next = temp_zone_pkg::ZONE_WARM;
        end else if (!cmp_s2.below_cold) begin
            zone_next = temp_zone_pkg::ZONE_COLD;
        end else if (!cmp_s2.below_cool) begin
            zone_next = temp_zone_pkg::ZONE_COOL;
        end else begin
            zone_next = temp_zone_pkg::ZONE_NORMAL;
        end
        state_next = state_reg;
        saved_next = saved_reg;
        if (state_reg == temp_zone_pkg::ST_TEMP_FLT) begin
            if (!fault_zone) begin
                state_next = saved_reg;
            end
        end else if (fault_zone) begin
            saved_next = state_reg;
            state_next = temp_zone_pkg::ST_TEMP_FLT;
        end else if (core_next_state != temp_zone_pkg::ST_TEMP_FLT) begin
            state_next = core_next_state;
        end
    end

    // zone and state storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zone_reg <= temp_zone_pkg::ZONE_OFF;
            state_reg <= temp_zone_pkg::ST_OFF;
            saved_reg <= temp_zone_pkg::ST_OFF;
        end else begin
            zone_reg <= zone_next;
            state_reg <= state_next;
            saved_reg <= saved_next;
        end
    end

    // ==========================================================
    // output selection
    always_comb begin
        // modified only in warm or cool
        mod_next = (zone_reg == temp_zone_pkg::ZONE_WARM) ||
                   (zone_reg == temp_zone_pkg::ZONE_COOL);
        volt_next = mod_next ? alt_cv_reg : cv_reg;
        curr_next = mod_next ? alt_cc_reg : cc_reg;
        pause_next = (state_next == temp_zone_pkg::ST_TEMP_FLT);
        bias_next = (valid_s2 && en_reg) || (mux_reg == `MUX_SENSE) ||
                    (mux_reg == `MUX_BIAS);
        mv_next[3] = trip_tbl({2'h0, trip_reg.cold});
        mv_next[2] = trip_tbl(4'(4'h2 + {2'h0, trip_reg.cool}));
        mv_next[1] = trip_tbl(4'(4'h6 + {2'h0, trip_reg.warm}));
        mv_next[0] = trip_tbl(4'(4'h8 + {2'h0, trip_reg.hot}));
    end

    // output storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_modified <= 1'b0;
            charge_voltage_out <= `CV_RESET;
            charge_current_out <= `CC_RESET;
            charge_paused <= 1'b0;
            sensor_bias_on <= 1'b0;
            trip_mv <= '0;
        end else begin
            temp_modified <= mod_next;
            charge_voltage_out <= volt_next;
            charge_current_out <= curr_next;
            charge_paused <= pause_next;
            sensor_bias_on <= bias_next;
            trip_mv <= mv_next;
        end
    end

    // probe select touches only bias and probe route
    assign analog_probe_sel = mux_reg;
    assign trip_sel = trip_reg;
    assign charge_state = state_reg;
    assign timers_paused = (state_reg == temp_zone_pkg::ST_TEMP_FLT);
    assign temp_irq = flag_reg[`FLAG_TEMP] && !mask_reg[`FLAG_TEMP];
    assign margin_irq = flag_reg[`FLAG_RAIL] && !mask_reg[`FLAG_RAIL];

    // ==========================================================
    // assertions
    sequence s_fault_held;
        state_reg == temp_zone_pkg::ST_TEMP_FLT;
    endsequence

    sequence s_fault_left;
        s_fault_held ##1 state_reg != temp_zone_pkg::ST_TEMP_FLT;
    endsequence

    property p_margin_lower;
        @(posedge pclk) disable iff (!presetn)
        margin_bad && !(wr && paddr == `ADDR_CHGV)
        |=> cv_reg == 6'($past(cv_reg) - 6'h01);
    endproperty
    a_margin_lower: assert property (p_margin_lower)
        else $error("voltage code not lowered on margin fault");

    property p_margin_flag;
        @(posedge pclk) disable iff (!presetn)
        margin_bad |=> flag_reg[`FLAG_RAIL];
    endproperty
    a_margin_flag: assert property (p_margin_flag)
        else $error("margin flag not raised");

    property p_normal_codes;
        @(posedge pclk) disable iff (!presetn)
        zone_reg == temp_zone_pkg::ZONE_NORMAL
        |=> !temp_modified && charge_voltage_out == $past(cv_reg);
    endproperty
    a_normal_codes: assert property (p_normal_codes)
        else $error("normal zone used modified codes");

    property p_alt_codes;
        @(posedge pclk) disable iff (!presetn)
        zone_reg == temp_zone_pkg::ZONE_WARM ||
        zone_reg == temp_zone_pkg::ZONE_COOL
        |=> temp_modified && charge_current_out == $past(alt_cc_reg);
    endproperty
    a_alt_codes: assert property (p_alt_codes)
        else $error("warm or cool zone missed alternate codes");

    property p_fault_enter;
        @(posedge pclk) disable iff (!presetn)
        fault_zone |=> s_fault_held ##0 charge_paused;
    endproperty
    a_fault_enter: assert property (p_fault_enter)
        else $error("hot or cold zone did not pause charging");

    property p_zone_flag;
        @(posedge pclk) disable iff (!presetn)
        zone_change |=> flag_reg[`FLAG_TEMP] && zone_reg == $past(zone_next);
    endproperty
    a_zone_flag: assert property (p_zone_flag)
        else $error("zone change did not set flag");

    property p_disabled;
        @(posedge pclk) disable iff (!presetn)
        !en_reg ##1 !en_reg |=> zone_reg == temp_zone_pkg::ZONE_OFF
                               && !temp_modified;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled monitor still applied changes");

    property p_bias;
        @(posedge pclk) disable iff (!presetn)
        (mux_reg == `MUX_SENSE || mux_reg == `MUX_BIAS ||
         (valid_s2 && en_reg)) |=> sensor_bias_on;
    endproperty
    a_bias: assert property (p_bias)
        else $error("sensor bias not switched on");

    property p_fault_return;
        @(posedge pclk) disable iff (!presetn)
        s_fault_left |-> state_reg == $past(saved_reg);
    endproperty
    a_fault_return: assert property (p_fault_return)
        else $error("fault exit did not restore prior state");

    property p_timers;
        @(posedge pclk) disable iff (!presetn)
        fault_zone ##1 s_fault_held |-> timers_paused && charge_paused;
    endproperty
    a_timers: assert property (p_timers)
        else $error("timers ran during temperature fault");

endmodule : battery_temp_zone_charge_control

// ---- battery_temp_zone_charge_control_bench.sv ----
// self-checking bench for the temperature zone charge control block
`timescale 1ns/1ps
`include "temp_zone_cfg.svh"

module battery_temp_zone_charge_control_bench;
    // zone table row: zone code, pause, modified, voltage, current
    typedef struct packed {
        logic [2:0] zone;
        logic       paused;
        logic       modified;
        logic [5:0] volt;
        logic [5:0] curr;
    } row_t;

    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, charge_input_valid = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic err, timers_paused, charge_paused, temp_modified;
    logic sensor_bias_on, temp_irq, margin_irq;
    logic [5:0] charge_voltage_out, charge_current_out;
    logic [3:0][10:0] trip_mv;
    logic [3:0] analog_probe_sel;
    temp_zone_pkg::zone_t zone = temp_zone_pkg::ZONE_NORMAL;
    temp_zone_pkg::cmp_t cmp_raw;
    temp_zone_pkg::chg_state_t core_next_state, charge_state;
    temp_zone_pkg::trip_sel_t trip_sel;
    int mismatches = 0;
    int n_tests = 0;
    row_t rows [9] = '{'{3'h3, 1'b0, 1'b0, 6'h14, 6'h08},
        '{3'h4, 1'b0, 1'b1, 6'h0A, 6'h05}, '{3'h5, 1'b1, 1'b0, 6'h0, 6'h0},
        '{3'h4, 1'b0, 1'b1, 6'h0A, 6'h05}, '{3'h3, 1'b0, 1'b0, 6'h14, 6'h08},
        '{3'h2, 1'b0, 1'b1, 6'h0A, 6'h05}, '{3'h1, 1'b1, 1'b0, 6'h0, 6'h0},
        '{3'h2, 1'b0, 1'b1, 6'h0A, 6'h05}, '{3'h3, 1'b0, 1'b0, 6'h14, 6'h08}};
    logic [31:0] cfgs [4] = '{32'h3900, 32'h73900, 32'h83900, 32'h73901};
    logic [7:0] stats [4] = '{8'h30, 8'hB0, 8'hB0, 8'hC5};

    battery_temp_zone_charge_control battery_temp_zone_charge_control_inst (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .cmp_raw, .charge_input_valid,
        .core_next_state, .charge_state, .timers_paused, .charge_paused,
        .temp_modified, .charge_voltage_out, .charge_current_out,
        .trip_sel, .trip_mv, .analog_probe_sel, .sensor_bias_on,
        .temp_irq, .margin_irq);

    thermistor_core_model thermistor_core_model_inst (
        .pclk, .presetn, .zone, .charge_valid(charge_input_valid),
        .cmp_raw, .core_next_state);

    // =========================================================
    // clock and shared tasks
    always #10 pclk = ~pclk;

    // compare one value and count it
    task automatic check(input string name, input logic [47:0] seen,
                         input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // let registered outputs land, then sample mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    // print counts and verdict, then stop
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // watchdog against a hang
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end

    // =========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_MASK, 32'h0);
        check("mask", rd, 32'h3); // masked at reset
        apb(1'b0, `ADDR_STAT, 32'h0);
        check("stat", rd, 32'h0); // zone off
        apb(1'b0, 8'h1C, 32'h0);
        check("slverr", err, 1'b1);
        check("unmapped", rd, 32'h0);
        // setup with rail kept well above the target
        charge_input_valid <= 1'b1;
        apb(1'b1, `ADDR_CFG, 32'h3901);
        apb(1'b1, `ADDR_CHGV, 32'h0A14);
        apb(1'b1, `ADDR_CHGI, 32'h0508);
        apb(1'b1, `ADDR_MASK, 32'h0);
        settle(2);
        check("trip_sel", trip_sel, 8'h39); // own selects
        check("trip_mv", trip_mv, {11'h400, 11'h2EB, 11'h19B,
              11'h16F}); // trip table
        apb(1'b0, `ADDR_STAT, 32'h0);
        // zone table walk
        for (int k = 0; k < 9; k++) begin
            zone <= temp_zone_pkg::zone_t'(rows[k].zone);
            settle(8);
            check("paused", charge_paused, rows[k].paused);
            check("timers", timers_paused, rows[k].paused);
            check("state", charge_state,
                  rows[k].paused ? 3'h4 : 3'h3);
            check("modified", temp_modified, rows[k].modified);
            if (!rows[k].paused) begin
                check("volt", charge_voltage_out, rows[k].volt);
                check("curr", charge_current_out, rows[k].curr);
            end
            check("temp_irq", temp_irq, 1'b1); // change interrupt
            apb(1'b0, `ADDR_STAT, 32'h0);
            check("stat", rd, {24'h0, 1'b1, rows[k].paused ? 3'h4 : 3'h3,
                  1'b0, rows[k].zone}); // return state
            apb(1'b0, `ADDR_FLAG, 32'h0);
            check("flag", rd, 32'h1); // sticky flag
            apb(1'b1, `ADDR_FLAG, 32'h1);
        end
        // bias, probe and disable cases with a hot battery
        zone <= temp_zone_pkg::ZONE_HOT;
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, `ADDR_CFG, cfgs[j]);
            settle(8);
            check("bias", sensor_bias_on, stats[j][7]);
            check("probe", analog_probe_sel, cfgs[j][19:16]);
            check("paused", charge_paused, stats[j][6]);
            apb(1'b0, `ADDR_STAT, 32'h0);
            check("stat", rd, {24'h0, stats[j]}); // probe independent
        end
        // rail margin violated on purpose
        zone <= temp_zone_pkg::ZONE_NORMAL;
        apb(1'b1, `ADDR_CFG, 32'h3901);
        apb(1'b1, `ADDR_FLAG, 32'h3);
        apb(1'b1, `ADDR_RAIL, 32'h10);
        settle(20);
        check("margin_irq", margin_irq, 1'b1); // margin interrupt
        check("volt", charge_voltage_out, 6'h08); // lowered code
        apb(1'b0, `ADDR_CHGV, 32'h0);
        check("chgv", rd, 32'h0A08); // field rewritten
        apb(1'b1, `ADDR_FLAG, 32'h3);
        settle(2);
        check("margin_irq", margin_irq, 1'b0); // margin now met
        check("temp_irq", temp_irq, 1'b0); // cleared by software
        // mid-run reset puts every output back to its reset value
        @(posedge pclk);
        presetn <= 1'b0;
        settle(2);
        check("state", charge_state, temp_zone_pkg::ST_OFF);
        check("volt", charge_voltage_out, `CV_RESET);
        check("curr", charge_current_out, `CC_RESET);
        check("bias", sensor_bias_on, 1'b0);
        check("margin_irq", margin_irq, 1'b0);
        check("temp_irq", temp_irq, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_CHGV, 32'h0);
        check("chgv", rd, 32'h1010); // fields back at reset
        finish_test();
    end
endmodule : battery_temp_zone_charge_control_bench

// ---- temp_zone_cfg.svh ----
// constants for the battery temperature zone charge control block
`ifndef TEMP_ZONE_CFG_SVH
`define TEMP_ZONE_CFG_SVH

// ==========================================================
// register byte offsets
`define ADDR_CFG    8'h00
`define ADDR_CHGV   8'h04
`define ADDR_CHGI   8'h08
`define ADDR_RAIL   8'h0C
`define ADDR_STAT   8'h10
`define ADDR_FLAG   8'h14
`define ADDR_MASK   8'h18

// ==========================================================
// field positions
`define CFG_EN_BIT    0
`define CFG_TRIP_LSB  8
`define CFG_MUX_LSB   16
`define ALT_LSB       8
`define FLAG_TEMP     0
`define FLAG_RAIL     1

// ==========================================================
// reset values
`define CV_RESET      6'h10
`define CC_RESET      6'h08
`define RAIL_RESET    6'h3F
`define MASK_RESET    2'h3

// ==========================================================
// voltage scales in millivolts
`define CV_BASE_MV    13'hE10
`define CV_STEP_MV    13'h019
`define RAIL_BASE_MV  13'hE10
`define RAIL_STEP_MV  13'h019
`define MARGIN_MV     13'h0C8

// ==========================================================
// probe channels that need the sensor biased
`define MUX_SENSE     4'h7
`define MUX_BIAS      4'h8

`endif

// ---- temp_zone_pkg.sv ----
// types shared by the temperature zone charge control block
package temp_zone_pkg;

    // ==========================================================
    // zone status codes
    typedef enum logic [2:0] {
        ZONE_OFF    = 3'h0,
        ZONE_COLD   = 3'h1,
        ZONE_COOL   = 3'h2,
        ZONE_NORMAL = 3'h3,
        ZONE_WARM   = 3'h4,
        ZONE_HOT    = 3'h5
    } zone_t;

    // charge states, gray coded along the charge path
    typedef enum logic [2:0] {
        ST_OFF        = 3'h0,
        ST_PREQUAL    = 3'h1,
        ST_FAST_CC    = 3'h3,
        ST_FAST_CV    = 3'h2,
        ST_TOP_OFF    = 3'h6,
        ST_DONE       = 3'h7,
        ST_TIMER_FLT  = 3'h5,
        ST_TEMP_FLT   = 3'h4
    } chg_state_t;

    // trip selects, second byte (bits 15:8) of a config field
    typedef struct packed {
        logic [1:0] cold;
        logic [1:0] cool;
        logic [1:0] warm;
        logic [1:0] hot;
    } trip_sel_t;

    // comparator results: sense voltage below each trip
    typedef struct packed {
        logic below_cold;
        logic below_cool;
        logic below_warm;
        logic below_hot;
    } cmp_t;

endpackage : temp_zone_pkg

// ---- thermistor_core_model.sv ----
// behavioural comparators and charger core facing the zone block
`timescale 1ns/1ps

module thermistor_core_model (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // stimulus from the bench
    input  wire temp_zone_pkg::zone_t      zone,
    input  wire logic                      charge_valid,
    // toward the block
    output temp_zone_pkg::cmp_t            cmp_raw,
    output temp_zone_pkg::chg_state_t      core_next_state
);
    temp_zone_pkg::chg_state_t core_reg;
    temp_zone_pkg::chg_state_t core_next;

    // =========================================================
    // comparators: hotter battery gives a lower sense voltage
    // trip ordering kept
    always_comb begin
        case (zone)
            temp_zone_pkg::ZONE_COLD: cmp_raw = 4'h0;
            temp_zone_pkg::ZONE_COOL: cmp_raw = 4'h8;
            temp_zone_pkg::ZONE_WARM: cmp_raw = 4'hE;
            temp_zone_pkg::ZONE_HOT:  cmp_raw = 4'hF;
            default:                  cmp_raw = 4'hC;
        endcase
    end

    // =========================================================
    // charger core: off, then prequal, then fast charge
    always_comb begin
        if (!charge_valid)
            core_next = temp_zone_pkg::ST_OFF;
        else if (core_reg == temp_zone_pkg::ST_OFF)
            core_next = temp_zone_pkg::ST_PREQUAL;
        else
            core_next = temp_zone_pkg::ST_FAST_CC;
    end

    // core state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            core_reg <= temp_zone_pkg::ST_OFF;
        else
            core_reg <= core_next;
    end

    assign core_next_state = core_reg;
endmodule : thermistor_core_model
